// ==== rtl/ecspw_pkg.sv ====
package ecspw_pkg;

	// ****************************************************************
	// Word format and timing
	// ****************************************************************

	// Bits in one register or result word.
	localparam int WORD_BITS = 24;
	// Width of the bit counter.
	localparam int CNT_W = 5;
	// Counter value after reset and at the start of every word.
	localparam logic [4:0] CNT_RESET = 5'h00;
	// Last bit index of a word.
	localparam logic [4:0] CNT_LAST = 5'h17;
	// Width of the calibration register address field.
	localparam int CAL_SEL_W = 2;

	// Source of a read word.
	typedef enum logic [1:0] {
		ECSPW_SRC_NONE,
		ECSPW_SRC_CTRL,
		ECSPW_SRC_OUT
	} ecspw_src_e;

	// One written word handed to the converter core.
	typedef struct packed {
		logic        to_cal;
		logic [23:0] data;
	} ecspw_wr_s;

	// Synchronised link pins.
	typedef struct packed {
		logic sclk;
		logic wr_n;
		logic rd_n;
		logic sel;
		logic sdi;
	} ecspw_pins_s;

endpackage

// ==== rtl/ecspw_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

// Two flip-flop synchroniser for a group of pin inputs.
module ecspw_sync #(
	parameter int W = 5
) (
	input  wire logic         mclk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	// First stage, read only by the second stage.
	logic [W-1:0] meta_q;

	// Both stages reset to ones, the idle level of the active-low frame strobes.
	// A reset value of zero would show open frames right after reset, and so a false frame edge.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= '1;
			dout   <= '1;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end

endmodule

`default_nettype wire

// ==== rtl/ecspw_port.sv ====
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Writes ignore and never change result_valid_n.
// - reg_select low control, high calibration.
// - Write bit captured on clock high.
// - MSB first; LSB on last high.
// - Resumed frame continues with next bit.
// - Control word readable with select low.
// - Read data leaves MSB first.
// - Ready low on new word unless an output read runs; high after output read.
// - Clock pin is input when clocking-select low.
// - Output read with ready high transfers nothing.
// - Select low reads control, high output, or the calibration word while cal_read is high.

module ecspw_port (
	input  wire logic               mclk,
	input  wire logic               rst_b,
	// Clocking-select pin; low means the host supplies the shift clock.
	input  wire logic               clk_mode_sel,
	// Shift clock pin, input side, and its drive outputs, held off since self-clocking mode is not built.
	input  wire logic               sclk_in,
	output logic                    sclk_out,
	output logic                    sclk_oe,
	input  wire logic               write_frame_n,
	input  wire logic               read_frame_n,
	input  wire logic               reg_select,
	// Two-way data pin.
	input  wire logic               serial_io_line_in,
	output logic                    serial_io_line_out,
	output logic                    serial_io_line_oe,
	output logic                    result_valid_n,
	// Converter core side.
	input  wire logic               new_word_stb,
	input  wire logic [23:0]        new_word,
	input  wire logic               cal_read,
	input  wire logic [23:0]        cal_word,
	output logic [23:0]             ctrl_word,
	output logic                    wr_stb,
	output ecspw_pkg::ecspw_wr_s    wr_word
);

	// ****************************************************************
	// Pin synchronisation
	// ****************************************************************

	// Synchronised pins.
	ecspw_pkg::ecspw_pins_s pins;

	ecspw_sync #(
		.W(5)
	) u_sync (
		.mclk (mclk),
		.rst_b(rst_b),
		.din  ({sclk_in, write_frame_n, read_frame_n, reg_select, serial_io_line_in}),
		.dout (pins)
	);

	// Synchronised clocking-select pin; it reads high for two cycles after reset.
	logic mode_sel_s;

	ecspw_sync #(
		.W(1)
	) u_sync_mode (
		.mclk (mclk),
		.rst_b(rst_b),
		.din  (clk_mode_sel),
		.dout (mode_sel_s)
	);

	// Previous synchronised shift clock, for edge finding.
	logic sclk_d1_q;
	logic sclk_rise;
	logic sclk_fall;

	// Only external clocking is implemented, so the pin stays an input.
	assign sclk_out = 1'b0;
	assign sclk_oe  = 1'b0;

	// Edges count only in external mode and inside a frame.
	assign sclk_rise = pins.sclk && !sclk_d1_q && !mode_sel_s
		&& !(pins.wr_n && pins.rd_n);
	assign sclk_fall = !pins.sclk && sclk_d1_q && !mode_sel_s
		&& !(pins.wr_n && pins.rd_n);

	// Shift clock delayed by one cycle; it resets to the synchroniser's reset level.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sclk_d1_q <= 1'b1;
		end else begin
			sclk_d1_q <= pins.sclk;
		end
	end

	// ****************************************************************
	// Write path
	// ****************************************************************

	// Write shift register, counter and select latched at word start.
	logic [23:0] wsh_q, wsh_d;
	logic [4:0]  wcnt_q, wcnt_d;
	logic        wsel_q, wsel_d;
	logic [23:0] ctrl_q, ctrl_d;
	logic        wstb_q, wstb_d;
	ecspw_pkg::ecspw_wr_s wword_q, wword_d;

	// Bits are taken on the rising edge, i.e. during the high phase.
	always_comb begin
		wsh_d   = wsh_q;
		wcnt_d  = wcnt_q;
		wsel_d  = wsel_q;
		ctrl_d  = ctrl_q;
		wstb_d  = 1'b0;
		wword_d = wword_q;
		if (sclk_rise && !pins.wr_n) begin
			// A paused word keeps its count and resumes on the next bit.
			wsh_d = {wsh_q[22:0], pins.sdi};
			if (wcnt_q == ecspw_pkg::CNT_RESET) begin
				// Select is held by the host; latch it at word start.
				wsel_d = pins.sel;
			end
			if (wcnt_q == ecspw_pkg::CNT_LAST) begin
				// The LSB arrives on the last high phase; deliver the word.
				wcnt_d       = ecspw_pkg::CNT_RESET;
				wstb_d       = 1'b1;
				wword_d.data = {wsh_q[22:0], pins.sdi};
				wword_d.to_cal = (wcnt_q == ecspw_pkg::CNT_RESET) ? pins.sel : wsel_q;
				if (!wword_d.to_cal) begin
					// Control target when select was low.
					ctrl_d = {wsh_q[22:0], pins.sdi};
				end
			end else begin
				wcnt_d = wcnt_q + 5'h01;
			end
		end
	end

	// Write registers.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wsh_q   <= '0;
			wcnt_q  <= ecspw_pkg::CNT_RESET;
			wsel_q  <= 1'b0;
			ctrl_q  <= '0;
			wstb_q  <= 1'b0;
			wword_q <= '0;
		end else begin
			wsh_q   <= wsh_d;
			wcnt_q  <= wcnt_d;
			wsel_q  <= wsel_d;
			ctrl_q  <= ctrl_d;
			wstb_q  <= wstb_d;
			wword_q <= wword_d;
		end
	end

	assign ctrl_word = ctrl_q;
	assign wr_stb    = wstb_q;
	assign wr_word   = wword_q;

	// ****************************************************************
	// Read path and result-ready flag
	// ****************************************************************

	// Output register, read shift register, counter and source.
	logic [23:0] outr_q, outr_d;
	logic [23:0] rsh_q, rsh_d;
	logic [4:0]  rcnt_q, rcnt_d;
	ecspw_pkg::ecspw_src_e src_q, src_d;
	logic        rdy_n_q, rdy_n_d;
	logic        rd_active_q, rd_active_d;
	logic        rd_prev_q;
	logic        rd_start;

	// A read frame begins on the falling edge of the synchronised strobe.
	assign rd_start = !pins.rd_n && rd_prev_q;

	// Read sequencing; writes never touch the ready flag.
	always_comb begin
		outr_d      = outr_q;
		rsh_d       = rsh_q;
		rcnt_d      = rcnt_q;
		src_d       = src_q;
		rdy_n_d     = rdy_n_q;
		rd_active_d = rd_active_q;
		// New words are lost to the user while an output read runs.
		if (new_word_stb && !(src_q == ecspw_pkg::ECSPW_SRC_OUT)) begin
			outr_d  = new_word;
			rdy_n_d = 1'b0;
		end else if (new_word_stb && src_q == ecspw_pkg::ECSPW_SRC_OUT) begin
			outr_d = new_word;
		end
		if (rd_start && src_q == ecspw_pkg::ECSPW_SRC_NONE) begin
			rcnt_d = ecspw_pkg::CNT_RESET;
			if (!pins.sel) begin
				src_d = ecspw_pkg::ECSPW_SRC_CTRL;
				rsh_d = ctrl_q;
			end else if (cal_read) begin
				// Calibration reads behave like control reads and leave the flag alone.
				src_d = ecspw_pkg::ECSPW_SRC_CTRL;
				rsh_d = cal_word;
			end else if (!rdy_n_q) begin
				src_d = ecspw_pkg::ECSPW_SRC_OUT;
				rsh_d = outr_q;
			end else begin
				src_d = ecspw_pkg::ECSPW_SRC_NONE;
			end
			rd_active_d = (src_d != ecspw_pkg::ECSPW_SRC_NONE);
		end
		if (sclk_fall && !pins.rd_n && rd_active_q) begin
			// Next bit leaves on the falling edge, MSB first.
			rsh_d = {rsh_q[22:0], 1'b0};
			if (rcnt_q == ecspw_pkg::CNT_LAST) begin
				// Whole word read: end the read; raise the flag after an output read.
				rd_active_d = 1'b0;
				src_d       = ecspw_pkg::ECSPW_SRC_NONE;
				if (src_q == ecspw_pkg::ECSPW_SRC_OUT) begin
					rdy_n_d = 1'b1;
				end
			end else begin
				rcnt_d = rcnt_q + 5'h01;
			end
		end
	end

	// Read registers; the flag idles high.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			outr_q      <= '0;
			rsh_q       <= '0;
			rcnt_q      <= ecspw_pkg::CNT_RESET;
			src_q       <= ecspw_pkg::ECSPW_SRC_NONE;
			rdy_n_q     <= 1'b1;
			rd_active_q <= 1'b0;
			rd_prev_q   <= 1'b1;
		end else begin
			outr_q      <= outr_d;
			rsh_q       <= rsh_d;
			rcnt_q      <= rcnt_d;
			src_q       <= src_d;
			rdy_n_q     <= rdy_n_d;
			rd_active_q <= rd_active_d;
			rd_prev_q   <= pins.rd_n;
		end
	end

	// Data pin is driven only while a read frame is open and running.
	assign serial_io_line_out = rsh_q[23];
	assign serial_io_line_oe  = rd_active_q && !pins.rd_n;
	assign result_valid_n     = rdy_n_q;

endmodule

`default_nettype wire

// ==== verif/ecspw_port_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// Watches the link pins and the core outputs of the serial port.
module ecspw_port_monitor (
	input wire logic                 mclk,
	input wire logic                 rst_b,
	input wire logic                 write_frame_n,
	input wire logic                 read_frame_n,
	input wire logic                 reg_select,
	input wire logic                 cal_read,
	input wire logic                 new_word_stb,
	input wire logic                 sclk_out,
	input wire logic                 sclk_oe,
	input wire logic                 serial_io_line_oe,
	input wire logic                 result_valid_n,
	input wire logic [23:0]          ctrl_word,
	input wire logic                 wr_stb,
	input wire ecspw_pkg::ecspw_wr_s wr_word
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// The read frame has stayed high for six clocks.
	sequence s_rd_quiet;
		read_frame_n[*6];
	endsequence
	property p_ready_hold;
		s_rd_quiet |-> !$rose(result_valid_n);
	endproperty
	a_ready_hold: assert property (p_ready_hold) else $error("ready rose outside a read");
	property p_oe_off;
		read_frame_n[*5] |-> !serial_io_line_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("data driven without a read frame");
	property p_refuse;
		$fell(read_frame_n) && result_valid_n && reg_select && !cal_read |-> (!serial_io_line_oe)[*8];
	endproperty
	a_refuse: assert property (p_refuse) else $error("output read ran with ready high");
	property p_ctrl;
		wr_stb && !wr_word.to_cal |-> ##[0:1] (ctrl_word == wr_word.data);
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control word not loaded");
	property p_cal;
		wr_stb && wr_word.to_cal |-> $stable(ctrl_word) ##1 $stable(ctrl_word);
	endproperty
	a_cal: assert property (p_cal) else $error("calibration write hit control word");
	property p_idle;
		(write_frame_n && read_frame_n)[*6] |-> !wr_stb;
	endproperty
	a_idle: assert property (p_idle) else $error("word taken with both frames high");
	property p_new;
		new_word_stb && read_frame_n |=> !result_valid_n;
	endproperty
	a_new: assert property (p_new) else $error("ready not lowered for new word");
	property p_pin;
		!sclk_oe && !sclk_out;
	endproperty
	a_pin: assert property (p_pin) else $error("shift clock pin driven");
endmodule
`default_nettype wire

// ==== verif/ecspw_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// Host side of the link: drives the shift clock, both frames, select and write data.
module ecspw_host (
	input  wire logic line,
	output logic      sclk,
	output logic      wf_n,
	output logic      rf_n,
	output logic      sel,
	output logic      dat
);
	// Idle state: frames high, clock low; both frames are driven separately.
	initial begin
		{sclk, sel, dat} = 3'h0;
		{wf_n, rf_n} = 2'h3;
	end
	// Moves n bits of w MSB first; read bits are shifted into r.
	task automatic shift(input logic wr, input logic s, input int n, input logic [23:0] w,
		inout logic [23:0] r);
		sel = s; // Select is held for the whole frame.
		#20;
		if (wr) wf_n = 1'b0; else rf_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			if (wr) dat = w[23];
			w = w << 1;
			#62.5 sclk = 1'b1;
			r = {r[22:0], line};
			#62.5 sclk = 1'b0;
			if (!wr) dat = ~dat; // A released line shows a changing level.
		end
		#30 wf_n = 1'b1;
		rf_n = 1'b1;
		dat = ~dat;
		#20;
	endtask
endmodule
`default_nettype wire

// ==== verif/test_ext_clock_serial_port_write.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_ext_clock_serial_port_write;
	logic                 mclk, rst_b, sclk, wf_n, rf_n, sel, dat, nstb, cal_read, so, soe;
	logic                 rdy, stb, saw_oe;
	logic [23:0]          nword, cal_word, ctrl, w, c, r;
	ecspw_pkg::ecspw_wr_s wrw;
	int                   err_total, n_compared, cyc;
	wire logic            line = soe ? so : dat;
	ecspw_port i_ecspw_port (.mclk(mclk), .rst_b(rst_b), .clk_mode_sel(1'b0), .sclk_in(sclk),
		.sclk_out(), .sclk_oe(), .write_frame_n(wf_n), .read_frame_n(rf_n), .reg_select(sel),
		.serial_io_line_in(line), .serial_io_line_out(so), .serial_io_line_oe(soe),
		.result_valid_n(rdy), .new_word_stb(nstb), .new_word(nword), .cal_read(cal_read),
		.cal_word(cal_word), .ctrl_word(ctrl), .wr_stb(stb), .wr_word(wrw));
	ecspw_host i_ecspw_host (.line(line), .sclk(sclk), .wf_n(wf_n), .rf_n(rf_n), .sel(sel),
		.dat(dat));
	// Expected written word: target flag above the data.
	function automatic logic [24:0] wexp(input logic cal, input logic [23:0] d);
		return {cal, d};
	endfunction
	// Bit order reversed inside each byte, as a least-significant-first host must do.
	function automatic logic [23:0] rev_bytes(input logic [23:0] v);
		logic [23:0] o;
		for (int b = 0; b < 24; b++) o[b] = v[(b / 8) * 8 + 7 - (b % 8)];
		return o;
	endfunction
	task automatic chk(input logic [24:0] seen, input logic [24:0] exp);
		n_compared++;
		if (seen !== exp) begin
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			err_total++;
		end
	endtask
	task automatic wrap_up();
		$display("compared %0d, wrong %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	always #5 mclk = ~mclk;
	// Sticky record of the data pin being driven, and the hang limit.
	always @(posedge mclk) begin
		if (soe) saw_oe = 1'b1;
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			wrap_up();
		end
	end
	initial begin
		{mclk, rst_b, nstb, cal_read, saw_oe} = 5'h00;
		{nword, cal_word, r} = 72'h0;
		w = 24'($urandom(34332));
		repeat (8) @(posedge mclk);
		#1 rst_b = 1'b1;
		for (int t = 0; t < 3; t++) begin
			w = 24'($urandom);
			c = 24'($urandom);
			repeat (5) @(posedge mclk);
			#1 nstb = 1'b1;
			nword = 24'($urandom);
			@(posedge mclk);
			#1 nstb = 1'b0;
			repeat (3) @(posedge mclk);
			chk(rdy, 1'b0);
			i_ecspw_host.shift(1'b1, 1'b0, 24, w, r);
			chk(ctrl, w);
			chk(wrw, wexp(1'b0, w));
			// The value c is the host's memory image, each byte held least significant bit first.
			for (int k = 0; k < 3; k++)
				i_ecspw_host.shift(1'b1, 1'b1, 8, rev_bytes(c) << (8 * k), r);
			chk(wrw, wexp(1'b1, rev_bytes(c)));
			chk(ctrl, w);
			chk(rdy, 1'b0);
			// Ready is low before each byte.
			for (int k = 0; k < 3; k++) i_ecspw_host.shift(1'b0, 1'b1, 8, 24'h0, r);
			chk(r, nword);
			repeat (5) @(posedge mclk);
			chk(rdy, 1'b1);
			saw_oe = 1'b0;
			i_ecspw_host.shift(1'b0, 1'b1, 24, 24'h0, r);
			chk(saw_oe, 1'b0);
			i_ecspw_host.shift(1'b0, 1'b0, 24, 24'h0, r);
			chk(r, w);
			@(posedge mclk);
			#1 cal_read = 1'b1;
			cal_word = 24'($urandom);
			i_ecspw_host.shift(1'b0, 1'b1, 24, 24'h0, r);
			chk(r, cal_word);
			@(posedge mclk);
			#1 cal_read = 1'b0;
			$display("test %0d done", t);
		end
		wrap_up();
	end
endmodule
bind ecspw_port ecspw_port_monitor i_ecspw_port_monitor (.mclk(mclk), .rst_b(rst_b),
	.write_frame_n(write_frame_n), .read_frame_n(read_frame_n), .reg_select(reg_select),
	.cal_read(cal_read), .new_word_stb(new_word_stb), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
	.serial_io_line_oe(serial_io_line_oe), .result_valid_n(result_valid_n),
	.ctrl_word(ctrl_word), .wr_stb(wr_stb), .wr_word(wr_word));
`default_nettype wire
